// ===== srp_serial_register_port.sv
// Serial register port: four-wire configuration link plus APB access to the same registers.
//
// Notes on behaviour
// R1 - A frame starts when select falls; bits are accepted only while select is low.
// R2 - Serial input is sampled on each rising serial clock edge during the frame.
// R3 - At select rise only the last 13 bits shifted in are kept.
// R4 - The kept word is one read/write bit, four address bits, eight data bits.
// R5 - The host sends the read/write bit as zero for a write.
// R6 - A write frame loads the data into the addressed register at select rise.
// R7 - The host requests a read with the read/write bit set and an address.
// R8 - A read frame ignores its data bits and leaves the register unchanged.
// R9 - At the next select fall the previously addressed register starts shifting out.
// R10 - Returned data goes out most significant bit first.
// R11 - The previous address is returned whether that frame was read or write.
// R12 - The serial output drives only while control 0 bit 6 is set.
// R13 - Word order is read/write bit, address MSB first, data MSB first.
// R14 - The output bit changes after falling serial clock edges.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module srp_serial_register_port
(
  input wire logic mclk,
  input wire logic rst,
  // Serial link pins.
  input wire logic ce_n,
  input wire logic sclk,
  input wire logic si_data,
  output logic so_data,
  output logic so_oe,
  // Register contents seen by the rest of the device, register n in bits 8n+7..8n.
  output logic [127:0] cfg_regs,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srp_pkg::PADDR_BITS-1:0] paddr,
  input wire logic [srp_pkg::PDATA_BITS-1:0] pwdata,
  output logic [srp_pkg::PDATA_BITS-1:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Link pins are asynchronous to mclk, so each passes two flops before any use.
  logic [srp_pkg::SYNC_STAGES-1:0] ce_sync;
  logic [srp_pkg::SYNC_STAGES-1:0] sclk_sync;
  logic [srp_pkg::SYNC_STAGES-1:0] si_sync;
  logic ce_q;
  logic sclk_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ce_sync <= '1;
      sclk_sync <= '0;
      si_sync <= '0;
      ce_q <= 1'b1;
      sclk_q <= 1'b0;
    end
    else
    begin
      ce_sync <= {ce_sync[0], ce_n};
      sclk_sync <= {sclk_sync[0], sclk};
      si_sync <= {si_sync[0], si_data};
      ce_q <= ce_sync[1];
      sclk_q <= sclk_sync[1];
    end
  end

  logic ce_low;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;

  assign ce_low = ~ce_sync[1];
  assign frame_start = ce_q & ~ce_sync[1]; // see R1
  assign frame_end = ~ce_q & ce_sync[1];
  // Input and output shifting only happen inside a frame.
  assign sclk_rise = ~sclk_q & sclk_sync[1] & ce_low; // see R1
  assign sclk_fall = sclk_q & ~sclk_sync[1] & ce_low;

  // Input shifter holds only the newest 13 bits; older bits fall off the top.
  logic [srp_pkg::FRAME_BITS-1:0] in_shift;
  logic [3:0] bit_count;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      in_shift <= '0;
      bit_count <= '0;
    end
    else if (frame_start)
    begin
      in_shift <= '0;
      bit_count <= '0;
    end
    else if (sclk_rise)
    begin
      in_shift <= {in_shift[srp_pkg::FRAME_BITS-2:0], si_sync[1]}; // see R2, R3
      // Saturating at 13 keeps a long frame complete without a wider counter.
      if (bit_count != srp_pkg::FRAME_BITS_CNT)
      begin
        bit_count <= bit_count + 4'h1;
      end
    end
  end

  // Decoding of the kept word.
  logic word_rw;
  logic [srp_pkg::ADDR_BITS-1:0] word_addr;
  logic [srp_pkg::DATA_BITS-1:0] word_data;
  logic frame_valid;
  logic serial_write;

  assign word_rw = in_shift[srp_pkg::RW_POS]; // see R4, R13
  assign word_addr = in_shift[srp_pkg::ADDR_MSB:srp_pkg::ADDR_LSB]; // see R4, R13
  assign word_data = in_shift[srp_pkg::DATA_MSB:0]; // see R4, R13
  // A frame shorter than 13 bits carries no complete word and is dropped.
  assign frame_valid = frame_end & (bit_count == srp_pkg::FRAME_BITS_CNT); // see R3
  assign serial_write = frame_valid & (word_rw == srp_pkg::RW_WRITE); // see R5, R6, R8

  // Address of the last complete frame, read or write, selects the next readback.
  logic [srp_pkg::ADDR_BITS-1:0] prev_addr;
  logic prev_rw;
  // The frame counter wraps; software only uses it to see that frames arrive.
  logic [7:0] frame_count;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prev_addr <= '0;
      prev_rw <= 1'b0;
      frame_count <= '0;
    end
    else if (frame_valid)
    begin
      prev_addr <= word_addr; // see R11
      prev_rw <= word_rw;
      frame_count <= frame_count + 8'h01;
    end
  end

  // APB decode. One wait state: pready rises in the second access cycle.
  logic apb_access;
  logic apb_done;
  logic [5:0] apb_index;
  logic apb_reg_hit;
  logic apb_status_hit;
  logic apb_write;

  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready;
  assign apb_index = paddr[7:2];
  assign apb_reg_hit = (paddr[1:0] == 2'b00) && (apb_index < 6'(srp_pkg::NUM_REGS));
  assign apb_status_hit = (paddr == srp_pkg::STATUS_ADDR);
  assign apb_write = apb_done & pwrite & apb_reg_hit;

  // Register file. A serial write to the same register in the same cycle beats APB.
  genvar gi;
  generate
    for (gi = 0; gi < srp_pkg::NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          cfg_regs[gi*8 +: 8] <= srp_pkg::REG_RESET[gi*8 +: 8];
        end
        else if (serial_write && (word_addr == 4'(gi)))
        begin
          cfg_regs[gi*8 +: 8] <= word_data; // see R6
        end
        else if (apb_write && (apb_index[3:0] == 4'(gi)))
        begin
          cfg_regs[gi*8 +: 8] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Readback shifter. The register is captured at select fall, so a write in the
  // same cycle is not a hazard: the commit happens at select rise, a frame earlier.
  logic [srp_pkg::DATA_BITS-1:0] out_shift;
  logic [srp_pkg::DATA_BITS-1:0] out_word;
  logic so_enable;

  assign out_word = cfg_regs[prev_addr*8 +: 8];
  assign so_enable = cfg_regs[srp_pkg::CTRL0_INDEX*8 + srp_pkg::CTRL0_SO_ENABLE_POS];

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      out_shift <= '0;
      so_data <= 1'b0;
    end
    else if (frame_start)
    begin
      so_data <= out_word[srp_pkg::DATA_MSB]; // see R9, R10, R11
      out_shift <= {out_word[srp_pkg::DATA_MSB-1:0], 1'b0};
    end
    else if (sclk_fall)
    begin
      // After the eighth bit the line carries zeros until the frame ends.
      so_data <= out_shift[srp_pkg::DATA_MSB]; // see R10, R14
      out_shift <= {out_shift[srp_pkg::DATA_MSB-1:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      so_oe <= 1'b0;
    end
    else
    begin
      so_oe <= ce_low & ~frame_end & so_enable; // see R12
    end
  end

  // APB answer path.
  logic [srp_pkg::PDATA_BITS-1:0] status_word;

  always_comb
  begin
    status_word = '0;
    status_word[srp_pkg::ST_ACTIVE_POS] = ce_low;
    status_word[srp_pkg::ST_ADDR_LSB +: srp_pkg::ADDR_BITS] = prev_addr;
    status_word[srp_pkg::ST_RW_POS] = prev_rw;
    status_word[srp_pkg::ST_COUNT_LSB +: 8] = frame_count;
  end

  // The answer is chosen apart from the handshake so that each flop keeps one concern.
  logic apb_take;
  logic next_pslverr;
  logic [srp_pkg::PDATA_BITS-1:0] next_prdata;

  assign apb_take = apb_access & ~pready;
  // The status word is read-only; writing it is an error like an unmapped address.
  assign next_pslverr = !(apb_reg_hit || (apb_status_hit && !pwrite));

  always_comb
  begin
    next_prdata = '0;
    if (!pwrite && apb_reg_hit)
    begin
      next_prdata = {24'h000000, cfg_regs[apb_index[3:0]*8 +: 8]};
    end
    else if (!pwrite && apb_status_hit)
    begin
      next_prdata = status_word;
    end
  end

  // One wait state: pready answers the second access cycle and drops in the next.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= apb_take;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pslverr <= 1'b0;
    end
    else if (apb_take)
    begin
      pslverr <= next_pslverr;
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // Read data is held after the answer; masters only take it while pready is high.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= '0;
    end
    else if (apb_take)
    begin
      prdata <= next_prdata;
    end
  end

endmodule // srp_serial_register_port
`default_nettype wire

// ===== srp_pkg.sv
// Constants shared by the serial register port design.
`default_nettype none
package srp_pkg;
  // Serial frame layout: a read/write bit, then the address, then the data, all MSB first.
  localparam int FRAME_BITS = 13;
  localparam int DATA_BITS = 8;
  localparam int ADDR_BITS = 4;
  localparam int RW_POS = 12;
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int NUM_REGS = 16;
  localparam logic [3:0] FRAME_BITS_CNT = 4'hd;
  localparam logic RW_WRITE = 1'b0;

  // Software control 0 and its serial output enable bit.
  localparam logic [3:0] CTRL0_INDEX = 4'hc;
  localparam int CTRL0_SO_ENABLE_POS = 6;

  // Power-on contents of the sixteen configuration registers, index 0 in the low byte.
  localparam logic [127:0] REG_RESET = 128'h5aaa_004e_1000_0000_0000_0000_0000_0000;

  // APB map: register n sits at byte address 4*n; the status word follows.
  localparam int PADDR_BITS = 8;
  localparam int PDATA_BITS = 32;
  localparam logic [5:0] STATUS_INDEX = 6'h10;
  localparam logic [PADDR_BITS-1:0] STATUS_ADDR = 8'h40;

  // Status word fields.
  localparam int ST_ACTIVE_POS = 0;
  localparam int ST_ADDR_LSB = 1;
  localparam int ST_RW_POS = 5;
  localparam int ST_COUNT_LSB = 8;

  // Link pin synchroniser depth.
  localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ===== srp_properties.sv
// Concurrent checks on the serial port pins and the APB handshake.
`timescale 1ns/1ns
`default_nettype none
module srp_properties
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic sclk,
  input wire logic so_data,
  input wire logic so_oe,
  input wire logic [127:0] cfg_regs,
  input wire logic psel,
  input wire logic penable,
  input wire logic [srp_pkg::PADDR_BITS-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_oe_on_start: assert property ($fell(ce_n) && cfg_regs[102] |-> ##[2:5] so_oe)
    else $error("oe late");
  a_oe_off_end: assert property ($rose(ce_n) |-> ##5 (!so_oe)[*3])
    else $error("oe stuck");
  a_oe_needs_ctrl: assert property ($rose(so_oe) |-> cfg_regs[102])
    else $error("oe without enable");
  a_so_hold_high: assert property ($rose(sclk) && !ce_n |-> ##1 $stable(so_data)[*3])
    else $error("so moved");
  a_cfg_hold: assert property (!ce_n && !$past(ce_n) && !$past(pready) |-> $stable(cfg_regs))
    else $error("reg moved");
  a_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready long");
  a_bad_addr: assert property (psel && penable && !pready && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("no slverr");
endmodule // srp_properties
bind srp_serial_register_port srp_properties props_u (.mclk, .rst, .ce_n, .sclk, .so_data,
  .so_oe, .cfg_regs, .psel, .penable, .paddr, .pready, .pslverr);
`default_nettype wire

// ===== srp_host_model.sv
// Behavioural host that sends serial frames and reads the port back.
`timescale 1ns/1ns
`default_nettype none
module srp_host_model
(
  input wire logic mclk,
  input wire logic so_data,
  input wire logic so_oe,
  output logic ce_n,
  output logic sclk,
  output logic si_data
);
  initial {ce_n, sclk, si_data} = 3'b100;
  // Idle input toggles so that a stale bit never looks like data.
  always @(posedge mclk)
    if (ce_n)
      si_data <= ~si_data;
  task automatic frame(input logic [19:0] w, input int n, output logic [7:0] rd,
    output logic oe);
    ce_n <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = n - 1; i >= 0; i--)
    begin
      si_data <= w[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      oe = (i == n - 1) ? so_oe : oe;
      // A released line shows the inverse of the driven bit, so stale data cannot pass.
      rd = (i >= n - 8) ? {rd[6:0], so_oe ? so_data : ~so_data} : rd;
      sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    ce_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule // srp_host_model
`default_nettype wire

// ===== tb_top.sv
// Bench: APB and serial frames checked against a register image.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t mismatch", $time); end end
module tb_top;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ce_n, sclk, si_data, so_data, so_oe, pready, pslverr, e, oe;
  logic [7:0] paddr = 8'h0, rd, ex [16];
  logic [7:0] bad [4] = '{8'h41, 8'h46, 8'h44, 8'h40};
  logic [31:0] pwdata = 32'h0, prdata, r, d, seed = 32'h62de;
  logic [127:0] cfg_regs;
  logic [3:0] a, pa = 4'h0;
  int err_count = 0, check_count = 0, nf = 0;
  always #5 mclk = ~mclk;
  srp_serial_register_port dut_u (.mclk, .rst, .ce_n, .sclk, .si_data, .so_data, .so_oe,
    .cfg_regs, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  srp_host_model host_u (.mclk, .so_data, .so_oe, .ce_n, .sclk, .si_data);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] status_exp(input logic [7:0] n, input logic rw,
    input logic [3:0] ad);
    return {16'h0000, n, 2'h0, rw, ad, 1'b0};
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t apb timeout", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic test_done();
    $display("Errors %0d, checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    test_done();
  end
  initial
  begin
    for (int i = 0; i < 16; i++)
      ex[i] = srp_pkg::REG_RESET[8 * i +: 8];
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK(r, {24'h0, ex[i]})
    end
    foreach (bad[j])
    begin
      apb(1'b1, bad[j], rnd());
      `CHK(e, 1'b1)
    end
    for (int k = 0; k < 24; k++)
    begin
      d = rnd();
      a = (d[11:8] == 4'hc) ? 4'h3 : d[11:8];
      if (k < 8)
      begin
        apb(1'b1, {2'h0, a, 2'h0}, d);
        ex[a] = d[7:0];
        apb(1'b0, {2'h0, a, 2'h0}, 32'h0);
        `CHK(r, {24'h0, ex[a]})
      end
      else
      begin
        host_u.frame({d[31:25], d[24], a, d[7:0]}, 13 + int'(d[22:20]), rd, oe);
        `CHK(rd, ex[pa])
        `CHK(oe, 1'b1)
        if (d[24] == srp_pkg::RW_WRITE)
          ex[a] = d[7:0];
        pa = a;
        nf++;
        `CHK(cfg_regs[8 * a +: 8], ex[a])
      end
    end
    // Twelve bits hold no complete word: nothing is written, the readback address stays.
    host_u.frame({7'h00, 1'b0, 4'h5, ~ex[5]}, 12, rd, oe);
    `CHK(rd, ex[pa])
    `CHK(cfg_regs[8 * 5 +: 8], ex[5])
    host_u.frame(20'h00c0e, 13, rd, oe);
    `CHK(rd, ex[pa])
    `CHK(cfg_regs[8 * 12 +: 8], 8'h0e)
    host_u.frame(20'h01000, 13, rd, oe);
    `CHK(oe, 1'b0)
    apb(1'b0, srp_pkg::STATUS_ADDR, 32'h0);
    `CHK(r, status_exp(8'(nf + 2), 1'b1, 4'h0))
    `CHK(e, 1'b0)
    test_done();
  end
endmodule // tb_top
`default_nettype wire
